// [testbench.sv]
/*
 * self-checking testbench of the pulse/sync timer
 * assumes: tmos_timer, tmos_far_end and tmos_regs.svh
 */
`timescale 1ns/10ps
`include "tmos_regs.svh"
module testbench;
    logic        clock;
    logic        sys_rst;
    logic [5:0]  tb_addr;
    logic [15:0] tb_wdata;
    logic        tb_wr;
    logic        tb_rd;
    logic [15:0] rdata;
    logic        trig;
    logic        ch0;
    logic        halted;
    logic        req;
    logic        dwr;
    logic [15:0] dwd;
    logic        slow;
    logic        upd_en;
    logic        upd;
    logic        grant;
    logic        oref;
    logic [15:0] a;
    logic [15:0] b;
    int          errors;
    int          cmp_count;
    int          n_ack;
    int          n_upd;
    int          k;

    // dma beats only take the port when the bench leaves it idle
    assign grant = dwr & ~(tb_wr | tb_rd);

    tmos_timer tmos_timer_inst
    (
        .clock                    (clock),
        .sys_rst                  (sys_rst),
        .reg_addr                 (grant ? `TMOS_DMABUF_ADDR : tb_addr),
        .reg_wdata                (grant ? dwd : tb_wdata),
        .reg_wr                   (tb_wr | grant),
        .reg_rd                   (tb_rd),
        .reg_rdata                (rdata),
        .iti1_in                  (upd),
        .channel0_input           (ch0),
        .trigger_out              (trig),
        .compare_reference_signal (oref),
        .cpu_halted               (halted),
        .dma_req                  (req),
        .dma_ack                  (grant)
    );

    tmos_far_end tmos_far_end_inst
    (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .dma_req   (req),
        .dma_ack   (grant),
        .slow      (slow),
        .dma_wr    (dwr),
        .dma_wdata (dwd),
        .upd_en    (upd_en),
        .upd_out   (upd)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        n_ack <= n_ack + int'(grant);
        n_upd <= n_upd + int'(upd);
    end

    // ****************************************
    // bus, compare and report tasks
    // ****************************************
    task automatic wr(input logic [5:0] ad, input logic [15:0] d);
        @(posedge clock);
        tb_addr <= ad;
        tb_wdata <= d;
        tb_wr <= 1'b1;
        @(posedge clock);
        tb_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] ad, output logic [15:0] d);
        @(posedge clock);
        tb_addr <= ad;
        tb_rd <= 1'b1;
        @(posedge clock);
        tb_rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic poll(input logic [5:0] ad, input int bt, input logic e);
        for (int i = 0; i < 40; i++)
        begin
            rd(ad, a);
            if (a[bt] === e)
                break;
        end
    endtask

    task automatic hi_count(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge clock);
            #1 h += int'(trig === 1'b1);
        end
    endtask

    task automatic dma_run(input logic [15:0] cfg, input logic sl, input int nb);
        int n0;
        n0 = n_ack;
        slow <= sl;
        wr(`TMOS_DMACFG_ADDR, cfg);
        wr(`TMOS_DMAEV_ADDR, 16'h0000);
        for (int i = 0; i < 200 && n_ack < n0 + nb; i++)
            @(posedge clock);
        cyc(10);
        chk("dma_beats", 16'(nb), 16'(n_ack - n0));
        chk("dma_req", 16'h0000, {15'h0000, req});
    endtask

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(`TMOS_RELOAD_ADDR, a);
        chk("reload_rst", `TMOS_RELOAD_RST, a);
        rd(`TMOS_CTL_ADDR, a);
        chk("ctl_rst", `TMOS_ZERO16, a);
        wr(6'h3e, 16'hffff);
        rd(6'h3e, a);
        chk("unmapped", `TMOS_ZERO16, a);
        // park dma beats from update events on an unmapped word
        wr(`TMOS_DMACFG_ADDR, 16'h003f);
        $display("test reset done");
    endtask

    task automatic t_oneshot;
        wr(`TMOS_RELOAD_ADDR, 16'h0020);
        wr(`TMOS_CTL_ADDR, 16'h0009);
        rd(`TMOS_CTL_ADDR, a);
        chk("run_held", 16'h1, {15'h0, a[0]});
        poll(`TMOS_CTL_ADDR, 0, 1'b0);
        chk("run_cleared", 16'h0, {15'h0, a[0]});
        cyc(8);
        rd(`TMOS_COUNT_ADDR, a);
        chk("count_reinit", 16'h0000, a);
        wr(`TMOS_RELOAD_ADDR, 16'h0100);
        wr(`TMOS_CTL_ADDR, 16'h0001);
        cyc(10);
        wr(`TMOS_CTL_ADDR, 16'h0000);
        rd(`TMOS_COUNT_ADDR, a);
        cyc(6);
        rd(`TMOS_COUNT_ADDR, b);
        chk("count_held", a, b);
        chk("count_moved", 16'h1, {15'h0, a != 16'h0000});
        $display("test one-shot done");
    endtask

    task automatic t_master;
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_MASTER_ADDR, {13'h0, `TMOS_MMS_ENABLE});
        wr(`TMOS_CTL_ADDR, 16'h0001);
        cyc(3);
        chk("trg_enable", 16'h1, {15'h0, trig});
        wr(`TMOS_CTL_ADDR, 16'h0000);
        cyc(3);
        chk("trg_disable", 16'h0, {15'h0, trig});
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_RELOAD_ADDR, 16'h0003);
        wr(`TMOS_MASTER_ADDR, {13'h0, `TMOS_MMS_UPDATE});
        wr(`TMOS_CTL_ADDR, 16'h0001);
        cyc(4);
        hi_count(16, k);
        chk("trg_update", 16'h4, 16'(k));
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_CHCTL_ADDR, {9'h0, `TMOS_OC_PWM_MODE_FIRST, 4'h0});
        wr(`TMOS_CMP0_ADDR, 16'h0002);
        wr(`TMOS_RELOAD_ADDR, 16'h0007);
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_MASTER_ADDR, {13'h0, `TMOS_MMS_CMP0});
        wr(`TMOS_CTL_ADDR, 16'h0001);
        cyc(4);
        hi_count(32, k);
        chk("trg_compare", 16'h8, 16'(k));
        wr(`TMOS_CTL_ADDR, 16'h0000);
        $display("test master done");
    endtask

    task automatic t_slave;
        logic [2:0] src;
        wr(`TMOS_RELOAD_ADDR, 16'hffff);
        for (int s = 0; s < 2; s++)
        begin
            src = s ? `TMOS_TRG_CI0ED : `TMOS_TRG_ITI1;
            wr(`TMOS_CTL_ADDR, 16'h0000);
            wr(`TMOS_STATUS_ADDR, 16'h0000);
            wr(`TMOS_SLAVE_ADDR, {9'h0, src, 1'b0, `TMOS_SM_EVENT});
            if (s == 0)
                upd_en <= 1'b1;
            else
                ch0 <= ~ch0;
            cyc(6);
            upd_en <= 1'b0;
            cyc(2);
            rd(`TMOS_CTL_ADDR, a);
            chk("event_run", 16'h1, {15'h0, a[0]});
            rd(`TMOS_STATUS_ADDR, a);
            chk("trig_flag", 16'h1, {15'h0, a[`TMOS_ST_TRIG]});
        end
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_SLAVE_ADDR, {8'h0, 1'b1, `TMOS_TRG_CI0ED, 1'b0, `TMOS_SM_EVENT});
        ch0 <= ~ch0;
        rd(`TMOS_CTL_ADDR, a);
        chk("msm_late", 16'h0, {15'h0, a[0]});
        rd(`TMOS_CTL_ADDR, a);
        chk("msm_start", 16'h1, {15'h0, a[0]});
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_SLAVE_ADDR, {9'h0, `TMOS_TRG_ITI1, 1'b0, `TMOS_SM_PAUSE});
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_CTL_ADDR, 16'h0001);
        cyc(10);
        rd(`TMOS_COUNT_ADDR, a);
        chk("pause_hold", 16'h0000, a);
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_SLAVE_ADDR, {9'h0, `TMOS_TRG_ITI1, 1'b0, `TMOS_SM_EXTCLK1});
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_CTL_ADDR, 16'h0001);
        k = n_upd;
        upd_en <= 1'b1;
        cyc(40);
        upd_en <= 1'b0;
        cyc(4);
        rd(`TMOS_COUNT_ADDR, a);
        chk("extclk_count", 16'(n_upd - k), a);
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_SLAVE_ADDR, 16'h0000);
        $display("test slave done");
    endtask

    task automatic t_fast;
        logic [2:0] md;
        wr(`TMOS_RELOAD_ADDR, 16'h0040);
        wr(`TMOS_CMP0_ADDR, 16'h0010);
        wr(`TMOS_SLAVE_ADDR, {9'h0, `TMOS_TRG_CI0ED, 1'b0, 3'h0});
        for (int m = 0; m < 2; m++)
        begin
            md = m ? 3'h1 : `TMOS_OC_PWM_MODE_FIRST;
            wr(`TMOS_CTL_ADDR, 16'h0000);
            wr(`TMOS_COUNT_ADDR, 16'h0000);
            wr(`TMOS_CHCTL_ADDR, {9'h0, md, 1'b0, 1'b1, 2'h0});
            wr(`TMOS_CTL_ADDR, 16'h0008);
            ch0 <= ~ch0;
            @(posedge clock);
            #1 chk("fast_ref", 16'(m), {15'h0, oref});
        end
        wr(`TMOS_CTL_ADDR, 16'h0000);
        wr(`TMOS_SLAVE_ADDR, 16'h0000);
        $display("test fast done");
    endtask

    task automatic t_dma;
        k = n_ack;
        dma_run(16'h0107, 1'b0, 2);
        rd(`TMOS_RELOAD_ADDR, a);
        chk("beat0", {8'h5a, 8'(k)}, a);
        rd(`TMOS_CMP0_ADDR, a);
        chk("beat1", {8'h5a, 8'(k + 1)}, a);
        dma_run(16'h0107, 1'b1, 2);
        rd(`TMOS_RELOAD_ADDR, a);
        chk("restart0", {8'h5a, 8'(k + 2)}, a);
        rd(`TMOS_CMP0_ADDR, a);
        chk("restart1", {8'h5a, 8'(k + 3)}, a);
        dma_run(16'h0007, 1'b0, 1);
        rd(`TMOS_RELOAD_ADDR, a);
        chk("single", {8'h5a, 8'(k + 4)}, a);
        rd(`TMOS_CMP0_ADDR, a);
        chk("single_only", {8'h5a, 8'(k + 3)}, a);
        wr(`TMOS_DMACFG_ADDR, 16'h003f);
        $display("test dma done");
    endtask

    task automatic t_debug;
        wr(`TMOS_COUNT_ADDR, 16'h0000);
        wr(`TMOS_CTL_ADDR, 16'h0011);
        halted <= 1'b1;
        cyc(2);
        rd(`TMOS_COUNT_ADDR, a);
        cyc(8);
        rd(`TMOS_COUNT_ADDR, b);
        chk("halt_hold", a, b);
        halted <= 1'b0;
        cyc(4);
        rd(`TMOS_COUNT_ADDR, a);
        chk("halt_release", 16'h1, {15'h0, a != b});
        wr(`TMOS_CTL_ADDR, 16'h0000);
        $display("test debug done");
    endtask

    initial
    begin
        #40000;
        errors++;
        stop_test;
    end

    initial
    begin
        sys_rst = 1'b1;
        tb_addr = 6'h00;
        tb_wdata = 16'h0000;
        tb_wr = 1'b0;
        tb_rd = 1'b0;
        ch0 = 1'b0;
        halted = 1'b0;
        slow = 1'b0;
        upd_en = 1'b0;
        errors = 0;
        cmp_count = 0;
        n_ack = 0;
        n_upd = 0;
        cyc(3);
        sys_rst <= 1'b0;
        t_reset;
        t_oneshot;
        t_master;
        t_slave;
        t_fast;
        t_dma;
        t_debug;
        stop_test;
    end
endmodule

// [tmos_far_end.sv]
/*
 * far side of the timer: a dma controller and a master timer
 * assumes: one clock; a dma beat counts as done when dma_ack is high
 */
`timescale 1ns/10ps
module tmos_far_end
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // dma
    input  wire logic        dma_req,
    input  wire logic        dma_ack,
    input  wire logic        slow,
    output logic             dma_wr,
    output logic      [15:0] dma_wdata,
    // master timer
    input  wire logic        upd_en,
    output logic             upd_out
);
    logic [7:0] nacks;
    logic [1:0] dly;
    logic [1:0] div;

    assign dma_wdata = {8'h5a, nacks};

    // ****************************************
    // beat held until granted, then next word
    // ****************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dma_wr <= 1'b0;
            nacks <= 8'h00;
            dly <= 2'h0;
            div <= 2'h0;
            upd_out <= 1'b0;
        end
        else
        begin
            if (dma_wr && dma_ack)
            begin
                dma_wr <= 1'b0;
                nacks <= nacks + 8'h01;
                dly <= slow ? 2'h3 : 2'h0;
            end
            else if (dly != 2'h0)
                dly <= dly - 2'h1;
            else if (dma_req && !dma_wr)
                dma_wr <= 1'b1;
            // one update pulse every fourth clock
            div <= upd_en ? div + 2'h1 : 2'h0;
            upd_out <= upd_en && div == 2'h3;
        end
    end
endmodule

// [tmos_pkg.sv]
/*
 * types of the pulse/sync timer
 * assumes: the offsets live in tmos_regs.svh
 */
package tmos_pkg;
    typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_DONE} tmos_dma_t;
endpackage

// [tmos_regs.svh]
/*
 * register offsets, field positions and reset values of the pulse/sync timer
 * assumes: included by the timer core and its package users, no logic here
 */
`ifndef TMOS_REGS_SVH
`define TMOS_REGS_SVH

// ****************************************
// register word offsets
// ****************************************
`define TMOS_CTL_ADDR      6'h00
`define TMOS_MASTER_ADDR   6'h01
`define TMOS_SLAVE_ADDR    6'h02
`define TMOS_STATUS_ADDR   6'h03
`define TMOS_CHCTL_ADDR    6'h04
`define TMOS_COUNT_ADDR    6'h05
`define TMOS_PRESC_ADDR    6'h06
`define TMOS_RELOAD_ADDR   6'h07
`define TMOS_CMP0_ADDR     6'h08
`define TMOS_DMACFG_ADDR   6'h09
`define TMOS_DMABUF_ADDR   6'h0a
`define TMOS_DMAEV_ADDR    6'h0b

// ****************************************
// control fields
// ****************************************
`define TMOS_CTL_RUN       0
`define TMOS_CTL_ONESHOT   3
`define TMOS_CTL_HOLD      4

// ****************************************
// master, slave, status, channel and dma fields
// ****************************************
`define TMOS_MMS_ENABLE    3'h1
`define TMOS_MMS_UPDATE    3'h2
`define TMOS_MMS_CMP0      3'h4
`define TMOS_TRG_ITI1      3'h1
`define TMOS_TRG_CI0ED     3'h4
`define TMOS_SM_PAUSE      3'h5
`define TMOS_SM_EVENT      3'h6
`define TMOS_SM_EXTCLK1    3'h7
`define TMOS_SM_MSM        7
`define TMOS_ST_TRIG       6
`define TMOS_OC_PWM_MODE_FIRST       3'h6
`define TMOS_OC_PWM_MODE_SECOND       3'h7
`define TMOS_CH_FAST       2
`define TMOS_DMA_STEP      6'h01

// ****************************************
// reset values
// ****************************************
`define TMOS_RELOAD_RST    16'hffff
`define TMOS_ZERO16        16'h0000

`endif

// [tmos_timer.sv]
/*
 * one-shot timer with master/slave trigger logic, dma burst port and debug hold
 * assumes: single clock, register port with read data one cycle later,
 * dma controller keeps accessing the transfer buffer, one word per access, while the request stays high
 */
`timescale 1ns/10ps
`include "tmos_regs.svh"

module tmos_timer
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // triggers
    input  wire logic        iti1_in,
    input  wire logic        channel0_input,
    output logic             trigger_out,
    output logic             compare_reference_signal,
    // debug
    input  wire logic        cpu_halted,
    // dma
    output logic             dma_req,
    input  wire logic        dma_ack
);

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] ctl, master, slave, status, chctl, count, presc, reload, cmp0, dmacfg;
    logic [15:0] next_ctl, next_master, next_slave, next_status, next_chctl;
    logic [15:0] next_count, next_presc, next_reload, next_cmp0, next_dmacfg;
    logic [15:0] pcnt, next_pcnt, rdata, next_rdata;
    logic        ci0_d, iti1_d, trg_d, msm_pend, ocref, trgout;
    logic        next_ci0_d, next_iti1_d, next_trg_d, next_msm_pend, next_ocref, next_trgout;
    tmos_pkg::tmos_dma_t dstate, next_dstate;
    logic [5:0]  doff, next_doff;

    // internal write port shared by cpu and dma buffer
    logic [5:0]  wa;
    logic        we;
    logic        trg_raw, trg_edge, trg_act, upd, tick, run, fast_ok, dma_ev;

    function automatic logic [5:0] map_addr(input logic [5:0] a, input logic [5:0] base,
                                            input logic [5:0] off);
        map_addr = (a == `TMOS_DMABUF_ADDR) ? base + off : a;
    endfunction

    // ****************************************
    // trigger selection and slave logic
    // ****************************************
    always_comb
    begin
        case (slave[6:4])
            `TMOS_TRG_ITI1:  trg_raw = iti1_in;
            `TMOS_TRG_CI0ED: trg_raw = channel0_input ^ ci0_d;
            default:         trg_raw = 1'b0;
        endcase
        trg_edge = (slave[6:4] == `TMOS_TRG_CI0ED) ? trg_raw : (trg_raw & ~iti1_d);
        trg_act  = slave[`TMOS_SM_MSM] ? msm_pend : trg_edge;
    end

    // ****************************************
    // counter
    // ****************************************
    always_comb
    begin
        we       = reg_wr;
        wa       = map_addr(reg_addr, dmacfg[5:0], doff);
        next_ctl = ctl;
        next_master = master;
        next_slave  = slave;
        next_chctl  = chctl;
        next_reload = reload;
        next_cmp0   = cmp0;
        next_dmacfg = dmacfg;
        next_status = status;
        next_count  = count;
        next_presc  = presc;
        next_pcnt   = pcnt;
        next_ocref  = ocref;
        next_ci0_d  = channel0_input;
        next_iti1_d = trg_raw;
        next_trg_d  = trg_act;
        next_msm_pend = slave[`TMOS_SM_MSM] & trg_edge;
        if (we)
        begin
            case (wa)
                `TMOS_CTL_ADDR:    next_ctl = reg_wdata;
                `TMOS_MASTER_ADDR: next_master = reg_wdata;
                `TMOS_SLAVE_ADDR:  next_slave = reg_wdata;
                `TMOS_STATUS_ADDR: next_status = status & reg_wdata;
                `TMOS_CHCTL_ADDR:  next_chctl = reg_wdata;
                `TMOS_COUNT_ADDR:  next_count = reg_wdata;
                `TMOS_PRESC_ADDR:  next_presc = reg_wdata;
                `TMOS_RELOAD_ADDR: next_reload = reg_wdata;
                `TMOS_CMP0_ADDR:   next_cmp0 = reg_wdata;
                `TMOS_DMACFG_ADDR: next_dmacfg = reg_wdata;
                default: ;
            endcase
        end
        run = ctl[`TMOS_CTL_RUN];
        // trigger start: one-shot or event mode sets run bit
        if (trg_act && (ctl[`TMOS_CTL_ONESHOT] || slave[2:0] == `TMOS_SM_EVENT))
            next_ctl[`TMOS_CTL_RUN] = 1'b1;
        if (trg_act && slave[2:0] != 3'h0)
            next_status[`TMOS_ST_TRIG] = 1'b1;
        fast_ok = trg_act && ctl[`TMOS_CTL_ONESHOT] && chctl[`TMOS_CH_FAST]
                  && (chctl[6:4] == `TMOS_OC_PWM_MODE_FIRST || chctl[6:4] == `TMOS_OC_PWM_MODE_SECOND);
        // prescaled clock, or trigger edges in external clock 1
        tick = 1'b0;
        if (run && !(cpu_halted && ctl[`TMOS_CTL_HOLD]))
        begin
            case (slave[2:0])
                `TMOS_SM_EXTCLK1: tick = trg_act;
                `TMOS_SM_PAUSE:   tick = trg_raw && (pcnt == presc);
                default:          tick = (pcnt == presc);
            endcase
            if (slave[2:0] != `TMOS_SM_EXTCLK1 &&
                (slave[2:0] != `TMOS_SM_PAUSE || trg_raw))
                next_pcnt = (pcnt == presc) ? 16'h0000 : pcnt + 16'h0001;
        end
        upd = tick && (count == reload);
        if (tick)
            next_count = upd ? `TMOS_ZERO16 : count + 16'h0001;
        if (upd && ctl[`TMOS_CTL_ONESHOT])
        begin
            next_ctl[`TMOS_CTL_RUN] = 1'b0;
            next_count = `TMOS_ZERO16;
            next_pcnt  = 16'h0000;
        end
        // compare reference: pwm mode 1 active below compare
        if (fast_ok)
            next_ocref = (chctl[6:4] == `TMOS_OC_PWM_MODE_FIRST) ? 1'b0 : 1'b1;
        else if (tick || we)
            next_ocref = (chctl[6:4] == `TMOS_OC_PWM_MODE_SECOND) ^ (next_count < cmp0);
        case (master[2:0])
            `TMOS_MMS_ENABLE: next_trgout = run;
            `TMOS_MMS_UPDATE: next_trgout = upd;
            `TMOS_MMS_CMP0:   next_trgout = ocref;
            default:          next_trgout = 1'b0;
        endcase
    end

    // ****************************************
    // dma burst
    // ****************************************
    always_comb
    begin
        dma_ev      = upd || (reg_wr && reg_addr == `TMOS_DMAEV_ADDR);
        next_dstate = dstate;
        next_doff   = doff;
        case (dstate)
            tmos_pkg::DMA_IDLE:
                if (dma_ev)
                begin
                    next_dstate = tmos_pkg::DMA_REQ;
                    next_doff   = 6'h00;
                end
            tmos_pkg::DMA_REQ:
                if (dma_ack)
                begin
                    if (doff == dmacfg[13:8])
                        next_dstate = tmos_pkg::DMA_DONE;
                    else
                        next_doff = doff + `TMOS_DMA_STEP;
                end
            tmos_pkg::DMA_DONE:
                next_dstate = tmos_pkg::DMA_IDLE;
            default:
                next_dstate = tmos_pkg::DMA_IDLE;
        endcase
        if (dma_ev && dstate != tmos_pkg::DMA_REQ)
        begin
            next_dstate = tmos_pkg::DMA_REQ;
            next_doff   = 6'h00;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb
    begin
        next_rdata = 16'h0000;
        if (reg_rd)
        begin
            case (map_addr(reg_addr, dmacfg[5:0], doff))
                `TMOS_CTL_ADDR:    next_rdata = ctl;
                `TMOS_MASTER_ADDR: next_rdata = master;
                `TMOS_SLAVE_ADDR:  next_rdata = slave;
                `TMOS_STATUS_ADDR: next_rdata = status;
                `TMOS_CHCTL_ADDR:  next_rdata = chctl;
                `TMOS_COUNT_ADDR:  next_rdata = count;
                `TMOS_PRESC_ADDR:  next_rdata = presc;
                `TMOS_RELOAD_ADDR: next_rdata = reload;
                `TMOS_CMP0_ADDR:   next_rdata = cmp0;
                `TMOS_DMACFG_ADDR: next_rdata = dmacfg;
                default:           next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctl <= 16'h0000;
            master <= 16'h0000;
            slave <= 16'h0000;
            status <= 16'h0000;
            chctl <= 16'h0000;
            count <= `TMOS_ZERO16;
            presc <= 16'h0000;
            reload <= `TMOS_RELOAD_RST;
            cmp0 <= 16'h0000;
            dmacfg <= 16'h0000;
            pcnt <= 16'h0000;
            rdata <= 16'h0000;
            ci0_d <= 1'b0;
            iti1_d <= 1'b0;
            trg_d <= 1'b0;
            msm_pend <= 1'b0;
            ocref <= 1'b0;
            trgout <= 1'b0;
            dstate <= tmos_pkg::DMA_IDLE;
            doff <= 6'h00;
        end
        else
        begin
            ctl <= next_ctl;
            master <= next_master;
            slave <= next_slave;
            status <= next_status;
            chctl <= next_chctl;
            count <= next_count;
            presc <= next_presc;
            reload <= next_reload;
            cmp0 <= next_cmp0;
            dmacfg <= next_dmacfg;
            pcnt <= next_pcnt;
            rdata <= next_rdata;
            ci0_d <= next_ci0_d;
            iti1_d <= next_iti1_d;
            trg_d <= next_trg_d;
            msm_pend <= next_msm_pend;
            ocref <= next_ocref;
            trgout <= next_trgout;
            dstate <= next_dstate;
            doff <= next_doff;
        end
    end

    assign reg_rdata = rdata;
    assign trigger_out = trgout;
    assign compare_reference_signal = ocref;
    assign dma_req = (dstate == tmos_pkg::DMA_REQ);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_oneshot_stop: assert property (upd && ctl[`TMOS_CTL_ONESHOT] |=> !ctl[`TMOS_CTL_RUN] && count == 16'h0000) else $error("one-shot did not stop");
    a_sw_hold: assert property (reg_wr && reg_addr == `TMOS_CTL_ADDR && !reg_wdata[0] && !trg_act |=> ##1 $stable(count)) else $error("count moved after software stop");
    a_fast_force: assert property (fast_ok |=> ocref == (chctl[6:4] == `TMOS_OC_PWM_MODE_SECOND)) else $error("fast compare not forced");
    a_update_out: assert property (master[2:0] == `TMOS_MMS_UPDATE && upd |=> trigger_out) else $error("update not on trigger output");
    a_enable_out: assert property (master[2:0] == `TMOS_MMS_ENABLE |=> trigger_out == $past(run)) else $error("enable not on trigger output");
    a_event_run: assert property (slave[2:0] == `TMOS_SM_EVENT && trg_act |=> ctl[`TMOS_CTL_RUN]) else $error("event mode did not start");
    a_trig_flag: assert property (trg_act && slave[2:0] != 3'h0 |=> status[`TMOS_ST_TRIG]) else $error("trigger flag not set");
    a_debug_hold: assert property (cpu_halted && ctl[`TMOS_CTL_HOLD] && !we |=> $stable(count)) else $error("counter moved in debug hold");
    a_req_held: assert property (dma_req && !dma_ack |=> dma_req) else $error("dma request dropped");

    c_oneshot: cover property (ctl[`TMOS_CTL_ONESHOT] && upd);
    c_burst: cover property (dma_req && dma_ack && doff == 6'h03);
    c_msm: cover property (slave[`TMOS_SM_MSM] && trg_act);

endmodule
